// ==== verilog/cfi_top.sv ====
// Register-driven frame injector with an APB slave and two groups.
// Assumes APB master on clk, queue sinks with valid/ready per group.
`timescale 1ns/100ps

// Notes on behaviour
// [R1] Config bit 8 picks byte order: 0 network order, 1 little-endian; resets to 1.
// [R2] Each data register write appends the next 32 bits of the group's frame.
// [R3] Gap field 28:21 counts leading dummy bytes that are discarded.
// [R4] Writing 1 to abort bit 20 cancels the frame; bit self-clears.
// [R5] End bit 19 written before the last word marks the next word as last.
// [R6] Start bit 18 written with 1 begins a new frame; 0 does nothing.
// [R7] Start bit reads 1 until the first word has gone to the queue.
// [R8] Valid-bytes field 17:16 gives byte count of the last word.
// [R9] Valid-bytes coding applies to network-ordered word contents.
// [R10] Status bits 5:4 show each group's queue high watermark.
// [R11] Software should check the watermark before starting a frame.
// [R12] Status bits 3:2 show each group's FIFO can take a word.
// [R13] Status bits 1:0 show a frame is being loaded per group.
// [R14] Error bits stay set until software writes 1 to them.
// [R15] Error bit 1 sets on abort; the group returns to idle.
// [R16] Error bit 0 sets on a data write with no frame started.
// [R17] Config, data, control, error per group four bytes apart; one status.
// [R18] Once the last word is written into the slot the frame passes on; loading clears.
module cfi_top import cfi_pkg::*; (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Input queue system
    output cfi_q_word_t            iq_word  [NUM_GRP],
    input  wire logic [NUM_GRP-1:0] iq_ready,
    input  wire logic [NUM_GRP-1:0] queue_high_level_flag,
    // Interrupt
    output logic                   irq
);

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------
    logic        ack_q;
    logic [31:0] prdata_q;
    logic        hit_q;

    wire logic access = psel & penable;
    wire logic sample = access & ~ack_q;     // First access cycle
    wire logic wr_en  = access & ack_q & pwrite;

    // One wait state, then ready
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= sample;
        end
    end

    assign pready  = access & ack_q;
    assign prdata  = prdata_q;
    assign pslverr = pready & ~hit_q;

    // ------------------------------------------------------------
    // Per-group state
    // ------------------------------------------------------------
    logic                   swap_q   [NUM_GRP];
    logic [7:0]             gap_q    [NUM_GRP];
    logic [1:0]             vld_q    [NUM_GRP];
    logic [31:0]            wdata_q  [NUM_GRP];
    logic [1:0]             err_q    [NUM_GRP];
    logic [EVT_W-1:0]       ist_q    [NUM_GRP];
    logic [EVT_W-1:0]       ien_q    [NUM_GRP];
    logic [NUM_GRP-1:0]     sel_cfg, sel_wr, sel_ctrl, sel_err;
    logic [NUM_GRP-1:0]     rdy, prog, fpend, epend, gint;
    logic [31:0]            rd_cfg   [NUM_GRP];
    logic [31:0]            rd_ctrl  [NUM_GRP];
    logic [31:0]            rd_err   [NUM_GRP];

    wire logic sel_status = (paddr == OFF_STATUS);
    wire logic sel_ist    = (paddr == OFF_IRQ_ST);
    wire logic sel_iclr   = (paddr == OFF_IRQ_CLR);
    wire logic sel_ien    = (paddr == OFF_IRQ_EN);

    genvar g;
    generate
        for (g = 0; g < NUM_GRP; g++) begin : grp
            cfi_grp_cmd_t cmd;
            cfi_grp_evt_t evt;
            logic [EVT_W-1:0] ev_vec;

            // Address decode, copies four bytes apart
            assign sel_cfg[g]  = (paddr == 8'(OFF_CFG  + GRP_STEP * g));   // [R17]
            assign sel_wr[g]   = (paddr == 8'(OFF_WR   + GRP_STEP * g));
            assign sel_ctrl[g] = (paddr == 8'(OFF_CTRL + GRP_STEP * g));
            assign sel_err[g]  = (paddr == 8'(OFF_ERR  + GRP_STEP * g));

            // Control write turned into one-shot commands
            wire logic ctrl_wr = wr_en & sel_ctrl[g];
            assign cmd.byte_swap             = swap_q[g];
            assign cmd.leading_dummy_count   = ctrl_wr ? pwdata[CTRL_GAP_LSB +: 8] : gap_q[g];
            assign cmd.last_word_valid_count = vld_q[g];
            assign cmd.sof   = ctrl_wr & pwdata[CTRL_SOF_BIT];     // [R6]
            assign cmd.eof   = ctrl_wr & pwdata[CTRL_EOF_BIT];     // [R5]
            assign cmd.abort = ctrl_wr & pwdata[CTRL_ABORT_BIT];   // [R4]
            assign cmd.wr    = wr_en & sel_wr[g];                  // [R2]
            assign cmd.wdata = pwdata;

            cfi_group u_grp (
                .clk                (clk),
                .srst               (srst),
                .cmd                (cmd),
                .out_ready          (iq_ready[g]),
                .out_word           (iq_word[g]),
                .fifo_rdy           (rdy[g]),
                .frame_loading_flag (prog[g]),
                .first_pend         (fpend[g]),
                .eof_pend           (epend[g]),
                .evt                (evt)
            );

            // Event vector in interrupt bit order
            assign ev_vec = {evt.done, evt.wr_err, evt.aborted};

            // Config and control fields
            always_ff @(posedge clk) begin
                if (srst) begin
                    swap_q[g]  <= SWAP_RST;                        // [R1]
                    gap_q[g]   <= GAP_RST;
                    vld_q[g]   <= 2'h0;
                    wdata_q[g] <= 32'h0000_0000;
                end else begin
                    if (wr_en && sel_cfg[g]) begin
                        swap_q[g] <= pwdata[CFG_SWAP_BIT];         // [R1]
                    end
                    if (ctrl_wr) begin
                        gap_q[g] <= pwdata[CTRL_GAP_LSB +: 8];     // [R3]
                        vld_q[g] <= pwdata[CTRL_VLD_LSB +: 2];     // [R8]
                    end
                    if (cmd.wr) begin
                        wdata_q[g] <= pwdata;
                    end
                end
            end

            // Sticky errors, set beats clear
            always_ff @(posedge clk) begin
                if (srst) begin
                    err_q[g] <= 2'h0;
                end else begin
                    err_q[g] <= (err_q[g] & ~({2{wr_en & sel_err[g]}} & pwdata[1:0]))  // [R14]
                              | {evt.aborted, evt.wr_err};                            // [R15] [R16]
                end
            end

            // Interrupt status and enable
            always_ff @(posedge clk) begin
                if (srst) begin
                    ist_q[g] <= '0;
                    ien_q[g] <= '0;
                end else begin
                    ist_q[g] <= (ist_q[g] & ~({EVT_W{wr_en & sel_iclr}}
                                & pwdata[EVT_W*g +: EVT_W])) | ev_vec;
                    if (wr_en && sel_ien) begin
                        ien_q[g] <= pwdata[EVT_W*g +: EVT_W];
                    end
                end
            end

            assign gint[g] = |(ist_q[g] & ien_q[g]);

            // Read images
            assign rd_cfg[g]  = 32'(swap_q[g]) << CFG_SWAP_BIT;
            assign rd_ctrl[g] = (32'(gap_q[g]) << CTRL_GAP_LSB)
                              | (32'(epend[g]) << CTRL_EOF_BIT)
                              | (32'(fpend[g]) << CTRL_SOF_BIT)     // [R7]
                              | (32'(vld_q[g]) << CTRL_VLD_LSB);
            assign rd_err[g]  = 32'(err_q[g]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Shared status and interrupt
    // ------------------------------------------------------------
    wire logic [31:0] rd_status = (32'(queue_high_level_flag) << ST_WM_LSB)  // [R10]
                                | (32'(rdy) << ST_RDY_LSB)                   // [R12]
                                | (32'(prog) << ST_PROG_LSB);                // [R13]
    wire logic [31:0] rd_ist    = 32'({ist_q[1], ist_q[0]});
    wire logic [31:0] rd_ien    = 32'({ien_q[1], ien_q[0]});

    assign irq = |gint;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic        rd_hit;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = sel_status | sel_ist | sel_iclr | sel_ien;
        if (sel_status) begin
            rd_mux = rd_status;
        end else if (sel_ist) begin
            rd_mux = rd_ist;
        end else if (sel_ien) begin
            rd_mux = rd_ien;
        end
        for (int i = 0; i < NUM_GRP; i++) begin
            rd_hit = rd_hit | sel_cfg[i] | sel_wr[i] | sel_ctrl[i] | sel_err[i];
            if (sel_cfg[i]) begin
                rd_mux = rd_cfg[i];
            end
            if (sel_wr[i]) begin
                rd_mux = wdata_q[i];
            end
            if (sel_ctrl[i]) begin
                rd_mux = rd_ctrl[i];
            end
            if (sel_err[i]) begin
                rd_mux = rd_err[i];
            end
        end
    end

    // Capture read data and decode result in the first access cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata_q <= 32'h0000_0000;
            hit_q    <= 1'b0;
        end else if (sample) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            hit_q    <= rd_hit;
        end
    end

endmodule

// ==== verilog/cfi_pkg.sv ====
// Shared constants and carriers for the frame injector.
// Assumes one clock domain and an APB register port with 8-bit byte address.
package cfi_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_GRP  = 2;
    localparam int ADDR_W   = 8;
    localparam int GRP_STEP = 4;   // Byte spacing of per-group copies

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CFG     = 8'h00;
    localparam logic [7:0] OFF_WR      = 8'h08;
    localparam logic [7:0] OFF_CTRL    = 8'h10;
    localparam logic [7:0] OFF_STATUS  = 8'h18;
    localparam logic [7:0] OFF_ERR     = 8'h1c;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h24;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h28;
    localparam logic [7:0] OFF_IRQ_EN  = 8'h2c;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int  CFG_SWAP_BIT   = 8;
    localparam logic SWAP_RST      = 1'b1;
    localparam int  CTRL_GAP_LSB   = 21;
    localparam int  CTRL_ABORT_BIT = 20;
    localparam int  CTRL_EOF_BIT   = 19;
    localparam int  CTRL_SOF_BIT   = 18;
    localparam int  CTRL_VLD_LSB   = 16;
    localparam int  ST_WM_LSB      = 4;
    localparam int  ST_RDY_LSB     = 2;
    localparam int  ST_PROG_LSB    = 0;
    localparam int  ERR_ABORT_BIT  = 1;
    localparam int  ERR_WR_BIT     = 0;
    localparam int  EVT_W          = 3;   // Interrupt events per group
    localparam logic [7:0] GAP_RST = 8'h00;
    localparam logic [7:0] WORD_BYTES = 8'h04;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Command pulses and settings from registers into one group
    typedef struct packed {
        logic        byte_swap;
        logic [7:0]  leading_dummy_count;
        logic [1:0]  last_word_valid_count;
        logic        sof;
        logic        eof;
        logic        abort;
        logic        wr;
        logic [31:0] wdata;
    } cfi_grp_cmd_t;

    // Word handed to the input_queue_system
    typedef struct packed {
        logic        valid;
        logic        sof;
        logic        eof;
        logic        abort;
        logic [1:0]  nbytes;   // Valid-byte code on the last word
        logic [1:0]  skip;     // Leading bytes to drop on first word
        logic [31:0] data;     // Network order
    } cfi_q_word_t;

    // One-cycle events from a group
    typedef struct packed {
        logic done;
        logic wr_err;
        logic aborted;
    } cfi_grp_evt_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_LOAD = 1'b1
    } cfi_state_t;

endpackage

// ==== verilog/cfi_group.sv ====
// One injection group: frame state, gap discard and one-word slot.
// Assumes the queue side drains the slot with a valid/ready handshake.
`timescale 1ns/100ps
module cfi_group import cfi_pkg::*; (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   srst,
    // From registers
    input  cfi_grp_cmd_t cmd,
    // To queue system
    input  wire logic   out_ready,
    output cfi_q_word_t out_word,
    // Status and events
    output logic        fifo_rdy,
    output logic        frame_loading_flag,
    output logic        first_pend,
    output logic        eof_pend,
    output cfi_grp_evt_t evt
);
    cfi_state_t  state_q;
    cfi_q_word_t slot_q;
    logic [7:0]  skip_q;
    logic        eofp_q, first_q, loaded_q, sent_q;

    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    wire logic        loading = (state_q == ST_LOAD);
    wire logic        hs      = slot_q.valid & out_ready;
    wire logic [31:0] w       = cmd.wdata;
    wire logic [31:0] net_w   = cmd.byte_swap ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    wire logic        acc     = cmd.wr & loading & ~slot_q.valid;
    wire logic        drop    = acc & ~eofp_q & (skip_q >= WORD_BYTES);
    wire logic        kill    = (cmd.abort | cmd.sof) & loading;

    // Outputs
    assign out_word           = slot_q;
    assign fifo_rdy           = ~slot_q.valid;
    assign frame_loading_flag = loading;          // [R13]
    assign first_pend         = first_q;          // [R7]
    assign eof_pend           = eofp_q;
    assign evt.aborted        = kill;              // [R15]
    assign evt.wr_err         = cmd.wr & ~acc;     // [R16]
    assign evt.done           = hs & slot_q.eof;

    // ------------------------------------------------------------
    // Frame state and slot
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q  <= ST_IDLE;
            slot_q   <= '0;
            skip_q   <= GAP_RST;
            eofp_q   <= 1'b0;
            first_q  <= 1'b0;
            loaded_q <= 1'b0;
            sent_q   <= 1'b0;
        end else begin
            if (hs) begin
                slot_q.valid <= 1'b0;
                if (slot_q.sof) begin
                    first_q <= 1'b0;               // [R7]
                    sent_q  <= 1'b1;
                end
            end
            if (kill) begin                        // [R4] [R15]
                state_q <= ST_IDLE;
                eofp_q  <= 1'b0;
                first_q <= 1'b0;
                slot_q  <= '0;
                slot_q.valid <= sent_q | (hs & slot_q.sof);  // Marker only if queue saw data
                slot_q.abort <= sent_q | (hs & slot_q.sof);
            end
            if (cmd.sof) begin                     // [R6]
                state_q  <= ST_LOAD;
                skip_q   <= cmd.leading_dummy_count;
                eofp_q   <= 1'b0;
                first_q  <= 1'b1;
                loaded_q <= 1'b0;
                sent_q   <= 1'b0;
            end else if (cmd.eof && loading) begin
                eofp_q <= 1'b1;                    // [R5]
            end else if (drop) begin
                skip_q <= skip_q - WORD_BYTES;     // [R3]
            end else if (acc) begin                // [R2]
                slot_q.valid  <= 1'b1;
                slot_q.sof    <= ~loaded_q;
                slot_q.eof    <= eofp_q;           // [R5]
                slot_q.abort  <= 1'b0;
                slot_q.nbytes <= eofp_q ? cmd.last_word_valid_count : 2'h0; // [R8] [R9]
                slot_q.skip   <= loaded_q ? 2'h0 : skip_q[1:0];   // [R3]
                slot_q.data   <= net_w;            // [R1]
                skip_q        <= GAP_RST;
                loaded_q      <= 1'b1;
                if (eofp_q) begin
                    state_q <= ST_IDLE;            // [R18]
                    eofp_q  <= 1'b0;
                end
            end
        end
    end

endmodule

// ==== verif/cfi_checker.sv ====
// Port-level checks on the frame injector top: APB timing, status, queue words.
// Assumes one clock domain; attached to every cfi_top instance by the bind below.
`timescale 1ns/100ps
module cfi_checker import cfi_pkg::*; (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic               pready,
    input  wire logic [31:0]        prdata,
    input  wire logic               pslverr,
    // Input queue system
    input  cfi_q_word_t             iq_word [NUM_GRP],
    input  wire logic [NUM_GRP-1:0] iq_ready,
    input  wire logic [NUM_GRP-1:0] queue_high_level_flag,
    // Interrupt
    input  wire logic               irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // APB steps
    // ------------------------------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_status_rd;
        pready && !pwrite && paddr == OFF_STATUS;
    endsequence

    a_apb_one_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_err_decode: assert property (pready |-> pslverr == (paddr > 8'h2c || paddr[1:0] != 2'b00))
        else $error("pslverr does not match address decode");
    a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data not zero on write");
    a_status_wmark: assert property (s_status_rd |-> prdata[5:4] == $past(queue_high_level_flag))
        else $error("status watermark bits wrong");
    a_status_ready: assert property (s_status_rd |-> prdata[3:2] ==
            ~{$past(iq_word[1].valid), $past(iq_word[0].valid)})
        else $error("status ready bits wrong");
    a_reset_idle: assert property ($fell(srst) |-> !irq && !iq_word[0].valid && !iq_word[1].valid)
        else $error("outputs not idle after reset");

    // ------------------------------------------------------------
    // Queue word rules per group
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_GRP; g++) begin : g_q
        a_word_hold: assert property (iq_word[g].valid && !iq_ready[g] && !(psel && pwrite)
                |=> iq_word[g].valid && $stable(iq_word[g]))
            else $error("queue word changed before taken");
        a_skip_sof: assert property (iq_word[g].valid && !iq_word[g].sof |-> iq_word[g].skip == 2'b00)
            else $error("skip set on non-first word");
        a_nbytes_eof: assert property (iq_word[g].valid && !iq_word[g].eof |-> iq_word[g].nbytes == 2'b00)
            else $error("valid-byte code on non-last word");
        a_abort_clean: assert property (iq_word[g].valid && iq_word[g].abort
                |-> iq_word[g].data == 32'h0 && !iq_word[g].sof && !iq_word[g].eof)
            else $error("abort word carries frame fields");
    end
endmodule

bind cfi_top cfi_checker u_chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .iq_word(iq_word), .iq_ready(iq_ready),
    .queue_high_level_flag(queue_high_level_flag), .irq(irq));

// ==== verif/cfi_sink.sv ====
// Queue-side sink model: answers each group's word slot with a ready level.
// Assumes the injector clock and reset; stall selects slow, irregular answers.
`timescale 1ns/100ps
module cfi_sink import cfi_pkg::*; (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // Control from bench
    input  wire logic [NUM_GRP-1:0] stall,
    // To injector
    output logic      [NUM_GRP-1:0] ready
);
    logic [15:0] lfsr_q;

    // Ready steady when prompt, pseudo-random when stalling
    always_ff @(posedge clk) begin
        if (srst) begin
            lfsr_q <= 16'hace1;
            ready  <= '0;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            ready  <= ~stall | lfsr_q[1:0];
        end
    end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench: APB master, queue word model, reset/error/abort/frame tests.
// Assumes cfi_top with the cfi_sink model on its queue side.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module testbench import cfi_pkg::*;;
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h00011061;
    logic        pready, pslverr, irq, slv_q;
    logic [1:0]  iq_ready, wm = 2'b00, stall = 2'b00;
    cfi_q_word_t iq_word [NUM_GRP];
    cfi_q_word_t exp_q [NUM_GRP][$];
    cfi_q_word_t mon_e, e;
    int          bad_count = 0, compares = 0, cycles = 0;

    always #50 clk = ~clk;

    cfi_top dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .iq_word(iq_word), .iq_ready(iq_ready), .queue_high_level_flag(wm), .irq(irq));
    cfi_sink u_sink (.clk(clk), .srst(srst), .stall(stall), .ready(iq_ready));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic tally_and_finish();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Hang guard and queue word monitor
    always @(posedge clk) begin
        for (int g = 0; g < NUM_GRP; g++)
            if (iq_word[g].valid === 1'b1 && iq_ready[g] === 1'b1) begin
                mon_e = (exp_q[g].size() == 0) ? '0 : exp_q[g].pop_front();
                `CHK("iq_word", mon_e, iq_word[g])
            end
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // One APB transfer; read data lands in rd, error in slv_q
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        slv_q = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic drain(input int g);
        for (int k = 0; k < 400 && exp_q[g].size() > 0; k++) @(posedge clk);
        `CHK("drained", 0, exp_q[g].size())
    endtask

    // One frame: optional swap, gap bytes, valid-byte code, n real words
    task automatic frame(input int g, sw, gap, code, n);
        logic [7:0]  ca;
        logic [31:0] d;
        int          last, nr;
        ca = OFF_CTRL + 8'(4 * g);
        last = gap / 4 + n - 1;
        wm <= seed[1:0];
        apb(1'b1, OFF_CFG + 8'(4 * g), 32'(sw) << CFG_SWAP_BIT);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("wmark", wm, rd[5:4])
        apb(1'b1, ca, (32'(gap) << CTRL_GAP_LSB) | 32'h0004_0000);
        apb(1'b0, ca, 32'h0);
        `CHK("sof_rd", 1'b1, rd[CTRL_SOF_BIT])
        `CHK("gap_rd", 8'(gap), rd[28:21])
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("loading", 1'b1, rd[ST_PROG_LSB + g])
        for (int i = 0; i <= last; i++) begin
            if (i == last) apb(1'b1, ca, (32'(gap) << 21) | 32'h0008_0000 | (32'(code) << 16));
            rd = '0;
            for (nr = 0; nr < 100 && rd[ST_RDY_LSB + g] !== 1'b1; nr++) apb(1'b0, OFF_STATUS, 32'h0);
            `CHK("fifo_rdy", 1'b1, rd[ST_RDY_LSB + g])
            seed = lfsr(seed);
            d = seed;
            apb(1'b1, OFF_WR + 8'(4 * g), d);
            e = '0;
            e.valid = 1'b1;
            e.sof = (i == gap / 4);
            e.eof = (i == last);
            e.nbytes = e.eof ? 2'(code) : 2'b00;
            e.skip = e.sof ? 2'(gap % 4) : 2'b00;
            e.data = sw ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
            if (i >= gap / 4) exp_q[g].push_back(e);
        end
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("loaded", 1'b0, rd[ST_PROG_LSB + g])
        drain(g);
        $display("test frame g%0d sw%0d gap%0d code%0d done", g, sw, gap, code);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        // Reset values of the per-group config, control and error registers and the shared status
        for (int g = 0; g < NUM_GRP; g++) begin
            apb(1'b0, OFF_CFG + 8'(4 * g), 32'h0);
            `CHK("cfg_rst", 32'h0000_0100, rd)
            apb(1'b0, OFF_CTRL + 8'(4 * g), 32'h0);
            `CHK("ctrl_rst", 32'h0, rd)
            apb(1'b0, OFF_ERR + 8'(4 * g), 32'h0);
            `CHK("err_rst", 32'h0, rd)
        end
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("status_rst", 32'h0000_000c, rd)
        $display("test reset done");
        // Write error, sticky clear, interrupt, unmapped access
        apb(1'b1, OFF_WR + 8'h04, 32'h1234_5678);
        apb(1'b0, OFF_ERR + 8'h04, 32'h0);
        `CHK("wr_err", 32'h1, rd)
        apb(1'b1, OFF_IRQ_EN, 32'h10);
        @(negedge clk);
        `CHK("irq_on", 1'b1, irq)
        apb(1'b0, OFF_IRQ_ST, 32'h0);
        `CHK("irq_st", 32'h10, rd)
        apb(1'b1, OFF_IRQ_CLR, 32'h10);
        @(negedge clk);
        `CHK("irq_off", 1'b0, irq)
        apb(1'b1, OFF_ERR + 8'h04, 32'h0);
        apb(1'b0, OFF_ERR + 8'h04, 32'h0);
        `CHK("err_keep", 32'h1, rd)
        apb(1'b1, OFF_ERR + 8'h04, 32'h1);
        apb(1'b0, OFF_ERR + 8'h04, 32'h0);
        `CHK("err_clr", 32'h0, rd)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("slverr", 1'b1, slv_q)
        $display("test errors done");
        // Abort after the first word has gone to the queue
        apb(1'b1, OFF_CFG, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h0004_0000);
        seed = lfsr(seed);
        apb(1'b1, OFF_WR, seed);
        e = '0;
        e.valid = 1'b1;
        e.sof = 1'b1;
        e.data = seed;
        exp_q[0].push_back(e);
        rd = '1;
        for (int k = 0; k < 50 && rd[CTRL_SOF_BIT] !== 1'b0; k++) apb(1'b0, OFF_CTRL, 32'h0);
        `CHK("sof_gone", 1'b0, rd[CTRL_SOF_BIT])
        apb(1'b1, OFF_CTRL, 32'h0010_0000);
        e = '0;
        e.valid = 1'b1;
        e.abort = 1'b1;
        exp_q[0].push_back(e);
        apb(1'b0, OFF_CTRL, 32'h0);
        `CHK("abort_rd", 1'b0, rd[CTRL_ABORT_BIT])
        apb(1'b0, OFF_ERR, 32'h0);
        `CHK("abort_err", 32'h2, rd)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("abort_idle", 1'b0, rd[0])
        apb(1'b1, OFF_ERR, 32'h2);
        apb(1'b0, OFF_ERR, 32'h0);
        `CHK("abort_clr", 32'h0, rd)
        drain(0);
        $display("test abort done");
        // Frames on both groups with a stalling queue side
        stall <= 2'b11;
        for (int g = 0; g < NUM_GRP; g++)
            for (int k = 0; k < 4; k++) frame(g, k % 2, (k < 2) ? 0 : 5, k, k + 1);
        tally_and_finish();
    end
endmodule
